// ### src/cpc_map.vh
// Constants for the cache policy control block: register offsets,
// field positions, reset values and mode codes.
// Assumes a 32-bit APB slave with word-aligned registers.
// Notes on behaviour
// RULE1: Both bits set: no coherency, no miss replacement
// RULE2: Both-set write hit: exclusive to modified, shared stays
// RULE3: Both-set write miss goes to memory, no allocate
// RULE4: Both-set: snoops never invalidate; drop instructions do
// RULE5: Both-set: L1 ignores snoops, L2/L3 still snoop
// RULE6: No-writeback at bit 29; both clear gives writeback
// RULE7: Variants without mode: disable set means no-fill
// RULE8: Older variant both-set: snoops follow dual-processor strap
// RULE9: Parity checked and flagged only while snoops accepted
// RULE10: Page cache-off acts with paging, disable clear
// RULE11: Page write-through acts with paging, no-writeback clear
// RULE12: Base register cache-off governs page directory only
// RULE13: Base register write-through picks directory write policy
// RULE14: Base register bits never touch page tables
// RULE15: Global pages honoured only with global enable
// RULE16: Misc bit 6 disables L3 alone
// RULE17: External pins steer caching of memory areas
// RULE18: Older variant drives page attributes on pins
// RULE19: Region registers assign types to address ranges
// RULE20: Page attribute table types each page
// RULE21: Disable clear with no-writeback set faults, code 0
// RULE22: Both clear: normal mode, fills and snoops allowed
// RULE23: Disable set blocks caching globally
// RULE24: New settings apply after the write completes
`ifndef CPC_MAP_VH
`define CPC_MAP_VH
// Register byte offsets
`define CPC_OFF_PRIMARY   12'h000
`define CPC_OFF_PAGEBASE  12'h004
`define CPC_OFF_EXTENDED  12'h008
`define CPC_OFF_MISC      12'h00C
`define CPC_OFF_STATUS    12'h010
`define CPC_OFF_FAULT     12'h014
`define CPC_OFF_REGION    12'h020
`define CPC_OFF_ATTRTAB   12'h040
// Field positions
`define CPC_BIT_PAGING    31
`define CPC_BIT_CACHEDIS  30
`define CPC_BIT_NOWB      29
`define CPC_BIT_PGWT      3
`define CPC_BIT_PGOFF     4
`define CPC_BIT_GLBEN     7
`define CPC_BIT_L3DIS     6
// Reset values
`define CPC_RST_PRIMARY   32'h60000000
`define CPC_RST_ZERO      32'h00000000
`define CPC_FAULT_CODE    16'h0000
// Mode codes
`define CPC_MODE_NORMAL   2'h0
`define CPC_MODE_NOFILL   2'h1
`define CPC_MODE_NOCOH    2'h2
// Memory types
`define CPC_MT_UC         3'h0
`define CPC_MT_WC         3'h1
`define CPC_MT_WT         3'h4
`define CPC_MT_WP         3'h5
`define CPC_MT_WB         3'h6
`endif

// ### src/cpc_region_table.v
// Region type table: eight programmable ranges, each with base, mask and type.
// Assumes writes come from the APB slave in the top module.
`timescale 1ns/1ps
`include "cpc_map.vh"
module cpc_region_table (
    input  wire        clk,
    input  wire        reset,
    input  wire        wrEn,
    input  wire [2:0]  wrIdx,
    input  wire [31:0] wrData,
    input  wire [2:0]  rdIdx,
    output wire [31:0] rdData,
    input  wire [19:0] lookupPage,
    output reg  [2:0]  regionType,
    output reg         regionHit
);
    // Entry: [31:12] base page, [11:4] mask of upper page bits, [3] valid,
    // [2:0] memory type
    reg [31:0] entry_q [0:7];
    integer    i;                  // Reset loop index
    integer    j;                  // Lookup loop index

    // Entries cleared at reset, written one at a time
    always @(posedge clk) begin
        if (reset) begin
            for (i = 0; i < 8; i = i + 1) begin
                entry_q[i] <= `CPC_RST_ZERO;
            end
        end else if (wrEn) begin
            entry_q[wrIdx] <= wrData;
        end
    end

    assign rdData = entry_q[rdIdx];

    // Lowest matching valid entry gives the type of the range [RULE19]
    always @* begin
        regionType = `CPC_MT_WB;
        regionHit  = 1'b0;
        for (j = 7; j >= 0; j = j - 1) begin
            if (entry_q[j][3] &&
                ((entry_q[j][31:24] & entry_q[j][11:4]) ==
                 (lookupPage[19:12] & entry_q[j][11:4]))) begin
                regionType = entry_q[j][2:0];
                regionHit  = 1'b1;
            end
        end
    end
endmodule // cpc_region_table

// ### src/cpc_policy_top.v
// Cache policy control: control registers over APB, mode decode,
// per-access policy, snoop acceptance and external pin attributes.
// Assumes access and snoop inputs synchronous to clk.
`timescale 1ns/1ps
`include "cpc_map.vh"
module cpc_policy_top #(
    parameter HAS_NOCOH_MODE = 1,   // Variant keeps the both-bits-set mode
    parameter OLD_VARIANT    = 0    // Variant with attribute pins and strap-steered snoops
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        dualProcStrap,
    input  wire        accValid,
    input  wire        accWrite,
    input  wire        accHit,
    input  wire        accShared,
    input  wire        accIsDir,
    input  wire [31:0] accAddr,
    input  wire        pageCacheOffBit,
    input  wire        pageWriteThroughBit,
    input  wire        pageGlobalBit,
    input  wire [2:0]  pageAttrIdx,
    input  wire        extCacheEnableIn_n,
    input  wire        extWritePolicyIn,
    input  wire        snoopValid,
    input  wire [31:0] snoopAddr,
    input  wire        snoopParity,
    input  wire        cacheDropInstr,
    input  wire        cacheFlushDropInstr,
    output reg         accCacheable,
    output reg         accWriteThrough,
    output reg         accAllocate,
    output reg         accMemWrite,
    output reg         accSetModified,
    output reg         accGlobal,
    output reg         l3Cacheable,
    output reg         pageCacheOffPin,
    output reg         pageWriteThroughPin,
    output reg         l1SnoopEn,
    output reg         l23SnoopEn,
    output reg         snoopInvalidate,
    output reg         invalidateAll,
    output reg         addrParityErrOut_n,
    output reg         protectionFault,
    output wire [1:0]  cacheMode
);
    reg  [31:0] primaryControlReg_q;   // Paging, disable, no-writeback
    reg  [31:0] pageBaseControlReg_q;  // Directory attributes
    reg  [31:0] extendedControlReg_q;  // Global page enable
    reg  [31:0] miscFeatureReg_q;      // L3 disable
    reg  [31:0] pageAttrTable_q;       // Eight 4-bit type entries
    reg  [15:0] faultCode_q;           // Last fault error code
    reg  [7:0]  faultCount_q;          // Count of rejected writes
    wire        apbWrite;              // Access phase write
    wire        regionWr;              // Write into region table
    wire [31:0] regionRd;              // Region table read data
    wire [2:0]  regionType;            // Type of the accessed range
    wire        regionHit;             // Range matched
    wire        cacheDisable;          // Cache disable
    wire        noWriteBack;           // No writeback
    wire        pagingOn;              // Paging enabled
    reg  [2:0]  tableType;             // Type from page attribute table
    reg         pageOff;               // Effective page cache-off
    reg         pageWt;                // Effective page write-through
    reg         snoopAccept;           // Snoops taken by L1

    // Even parity over the address
    function parity_ok;
        input [31:0] a;
        input        p;
        begin
            parity_ok = ~(^a ^ p);
        end
    endfunction

    // Address falls in a given word
    function hit_off;
        input [11:0] a;
        input [11:0] off;
        begin
            hit_off = (a[11:2] == off[11:2]);
        end
    endfunction

    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign apbWrite = psel & penable & pwrite;
    assign regionWr = apbWrite && (paddr[11:5] == `CPC_OFF_REGION >> 5);
    assign cacheDisable = primaryControlReg_q[`CPC_BIT_CACHEDIS];
    assign noWriteBack  = primaryControlReg_q[`CPC_BIT_NOWB];    // [RULE6]
    assign pagingOn = primaryControlReg_q[`CPC_BIT_PAGING];

    // Mode decode; no-writeback ignored when mode is absent [RULE7]
    assign cacheMode = !cacheDisable ? `CPC_MODE_NORMAL :        // [RULE22]
                       (noWriteBack && HAS_NOCOH_MODE) ? `CPC_MODE_NOCOH :
                       `CPC_MODE_NOFILL;                         // [RULE1]

    // Control registers; settings hold until the completing write [RULE24]
    always @(posedge clk) begin
        if (reset) begin
            primaryControlReg_q  <= `CPC_RST_PRIMARY;
            pageBaseControlReg_q <= `CPC_RST_ZERO;
            extendedControlReg_q <= `CPC_RST_ZERO;
            miscFeatureReg_q     <= `CPC_RST_ZERO;
            pageAttrTable_q      <= `CPC_RST_ZERO;
            faultCode_q          <= `CPC_FAULT_CODE;
            faultCount_q         <= 8'h00;
            protectionFault      <= 1'b0;
        end else begin
            protectionFault <= 1'b0;
            if (apbWrite) begin
                if (hit_off(paddr, `CPC_OFF_PRIMARY)) begin
                    // Disable clear with no-writeback set is refused [RULE21]
                    if (!pwdata[`CPC_BIT_CACHEDIS] &&
                        pwdata[`CPC_BIT_NOWB]) begin
                        protectionFault <= 1'b1;
                        faultCode_q     <= `CPC_FAULT_CODE;
                        faultCount_q    <= faultCount_q + 8'h01;
                    end else begin
                        primaryControlReg_q <= pwdata;
                    end
                end
                if (hit_off(paddr, `CPC_OFF_PAGEBASE)) begin
                    pageBaseControlReg_q <= pwdata;
                end
                if (hit_off(paddr, `CPC_OFF_EXTENDED)) begin
                    extendedControlReg_q <= pwdata;
                end
                if (hit_off(paddr, `CPC_OFF_MISC)) begin
                    miscFeatureReg_q <= pwdata;
                end
                if (hit_off(paddr, `CPC_OFF_ATTRTAB)) begin
                    pageAttrTable_q <= pwdata;
                end
            end
        end
    end

    // Read mux; unmapped words read zero
    always @* begin
        prdata = `CPC_RST_ZERO;
        if (hit_off(paddr, `CPC_OFF_PRIMARY)) begin
            prdata = primaryControlReg_q;
        end else if (hit_off(paddr, `CPC_OFF_PAGEBASE)) begin
            prdata = pageBaseControlReg_q;
        end else if (hit_off(paddr, `CPC_OFF_EXTENDED)) begin
            prdata = extendedControlReg_q;
        end else if (hit_off(paddr, `CPC_OFF_MISC)) begin
            prdata = miscFeatureReg_q;
        end else if (hit_off(paddr, `CPC_OFF_STATUS)) begin
            prdata = {22'h000000, snoopAccept, l3Cacheable, 6'h00, cacheMode};
        end else if (hit_off(paddr, `CPC_OFF_FAULT)) begin
            prdata = {8'h00, faultCount_q, faultCode_q};
        end else if (hit_off(paddr, `CPC_OFF_ATTRTAB)) begin
            prdata = pageAttrTable_q;
        end else if (paddr[11:5] == `CPC_OFF_REGION >> 5) begin
            prdata = regionRd;
        end
    end

    // Region table lookup for the current access
    cpc_region_table uRegion (
        .clk        (clk),
        .reset      (reset),
        .wrEn       (regionWr),
        .wrIdx      (paddr[4:2]),
        .wrData     (pwdata),
        .rdIdx      (paddr[4:2]),
        .rdData     (regionRd),
        .lookupPage (accAddr[31:12]),
        .regionType (regionType),
        .regionHit  ()
    );

    // Page attribute table type for this page [RULE20]
    always @* begin
        case (pageAttrIdx)
            3'h0: tableType = pageAttrTable_q[2:0];
            3'h1: tableType = pageAttrTable_q[6:4];
            3'h2: tableType = pageAttrTable_q[10:8];
            3'h3: tableType = pageAttrTable_q[14:12];
            3'h4: tableType = pageAttrTable_q[18:16];
            3'h5: tableType = pageAttrTable_q[22:20];
            3'h6: tableType = pageAttrTable_q[26:24];
            default: tableType = pageAttrTable_q[30:28];
        endcase
    end

    // Effective page attributes; directory uses base register only
    always @* begin
        pageOff = 1'b0;
        pageWt  = 1'b0;
        if (pagingOn && !cacheDisable) begin
            if (accIsDir) begin
                // Base register steers the directory alone [RULE12] [RULE14]
                pageOff = pageBaseControlReg_q[`CPC_BIT_PGOFF];
            end else begin
                pageOff = pageCacheOffBit;                       // [RULE10]
            end
        end
        if (pagingOn && !noWriteBack) begin
            if (accIsDir) begin
                pageWt = pageBaseControlReg_q[`CPC_BIT_PGWT];    // [RULE13]
            end else begin
                pageWt = pageWriteThroughBit;                    // [RULE11]
            end
        end
    end

    // L1 snoop acceptance per mode and variant
    always @* begin
        snoopAccept = 1'b1;
        if (cacheMode == `CPC_MODE_NOCOH) begin
            if (OLD_VARIANT) begin
                snoopAccept = dualProcStrap;                     // [RULE8]
            end else begin
                snoopAccept = 1'b0;                              // [RULE5]
            end
        end
    end

    // Registered per-access policy and snoop outputs
    always @(posedge clk) begin
        if (reset) begin
            accCacheable        <= 1'b0;
            accWriteThrough     <= 1'b0;
            accAllocate         <= 1'b0;
            accMemWrite         <= 1'b0;
            accSetModified      <= 1'b0;
            accGlobal           <= 1'b0;
            l3Cacheable         <= 1'b0;
            pageCacheOffPin     <= 1'b0;
            pageWriteThroughPin <= 1'b0;
            l1SnoopEn           <= 1'b0;
            l23SnoopEn          <= 1'b0;
            snoopInvalidate     <= 1'b0;
            invalidateAll       <= 1'b0;
            addrParityErrOut_n  <= 1'b1;
        end else begin
            // Global caching block, then page, region, pin limits [RULE23]
            accCacheable <= accValid && !cacheDisable && !pageOff &&
                            extCacheEnableIn_n == 1'b0 &&        // [RULE17]
                            regionType != `CPC_MT_UC &&          // [RULE19]
                            tableType != `CPC_MT_UC;             // [RULE20]
            accWriteThrough <= accValid && (pageWt || extWritePolicyIn ||
                               regionType == `CPC_MT_WT);
            // Fills only in normal mode; misses never allocate otherwise
            // Uncached ranges and pages never fill either [RULE23]
            accAllocate <= accValid && !accHit && !cacheDisable &&
                           !pageOff && extCacheEnableIn_n == 1'b0 &&
                           regionType != `CPC_MT_UC &&
                           tableType != `CPC_MT_UC;  // [RULE1] [RULE3]
            // Misses and shared or page write-through hits reach memory
            accMemWrite <= accValid && accWrite &&
                           (!accHit || accShared || pageWt ||
                            (cacheDisable && !accHit));          // [RULE3]
            // Exclusive hit goes modified unless page write-through; shared stays shared [RULE2]
            accSetModified <= accValid && accWrite && accHit &&
                              !accShared && !pageWt;
            accGlobal <= accValid && pageGlobalBit &&
                         extendedControlReg_q[`CPC_BIT_GLBEN];   // [RULE15]
            // L3 off regardless of other controls [RULE16]
            l3Cacheable <= !miscFeatureReg_q[`CPC_BIT_L3DIS] &&
                           !cacheDisable;
            // Attribute pins follow the L1 view on the older variant
            pageCacheOffPin     <= OLD_VARIANT ? pageOff : 1'b0; // [RULE18]
            pageWriteThroughPin <= OLD_VARIANT ? pageWt : 1'b0;  // [RULE18]
            l1SnoopEn  <= snoopAccept;                           // [RULE5]
            l23SnoopEn <= 1'b1;                                  // [RULE5]
            // Snoop hits invalidate only outside the both-set mode
            snoopInvalidate <= snoopValid && snoopAccept &&
                               cacheMode != `CPC_MODE_NOCOH;     // [RULE4]
            invalidateAll <= cacheDropInstr | cacheFlushDropInstr; // [RULE4]
            // Parity checked only for accepted snoops [RULE9]
            addrParityErrOut_n <= !(snoopValid && snoopAccept &&
                                    !parity_ok(snoopAddr, snoopParity));
        end
    end
endmodule // cpc_policy_top

// ### testbench/cpc_policy_assertions.sv
// Checker for the cache policy block: fault, mode and snoop relations.
// Assumes it is bound to cpc_policy_top and sees only its ports.
`timescale 1ns/1ps
module cpc_policy_assertions (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        accValid,
    input wire logic        accWrite,
    input wire logic        accHit,
    input wire logic        accShared,
    input wire logic        snoopValid,
    input wire logic [31:0] snoopAddr,
    input wire logic        snoopParity,
    input wire logic        cacheDropInstr,
    input wire logic        cacheFlushDropInstr,
    input wire logic        accAllocate,
    input wire logic        accMemWrite,
    input wire logic        accSetModified,
    input wire logic        l1SnoopEn,
    input wire logic        l23SnoopEn,
    input wire logic        snoopInvalidate,
    input wire logic        invalidateAll,
    input wire logic        addrParityErrOut_n,
    input wire logic        protectionFault,
    input wire logic [1:0]  cacheMode
);
    logic parBad_q;  // Parity fault seen on the last snoop sample
    wire  illWr = psel & penable & pwrite & (paddr == 12'h000)
                  & ~pwdata[30] & pwdata[29];  // Disable clear, no-wb set
    // Parity of each snoop sample, kept for the next cycle
    always @(posedge clk) parBad_q <= ^{snoopAddr, snoopParity};
    logic rstDly_q;  // Reset seen one edge ago; masks the release edge
    always @(posedge clk) rstDly_q <= reset;
    default clocking @(posedge clk); endclocking
    default disable iff (reset || rstDly_q);
    sequence illegal_wr_s; illWr; endsequence
    sequence fault_pulse_s; protectionFault ##1 !protectionFault; endsequence
    a_fault_on_illegal: assert property (illegal_wr_s |=> fault_pulse_s)
        else $error("no single fault pulse after illegal write");
    a_mode_kept: assert property (illegal_wr_s |=> $stable(cacheMode))
        else $error("illegal write changed the mode");
    a_disable_no_alloc: assert property (cacheMode != 2'h0 |=> !accAllocate)
        else $error("allocation while cache disabled");
    a_nocoh_l1_quiet: assert property (cacheMode == 2'h2 |=> !l1SnoopEn && l23SnoopEn)
        else $error("snoop enables wrong in no-coherency mode");
    a_nocoh_snoop_keep: assert property (cacheMode == 2'h2 && snoopValid |=> !snoopInvalidate)
        else $error("snoop invalidated in no-coherency mode");
    a_drop_invalidates: assert property (cacheDropInstr || cacheFlushDropInstr |=> invalidateAll)
        else $error("drop instruction did not invalidate");
    a_parity_flag: assert property (cacheMode == 2'h0 && snoopValid |=> addrParityErrOut_n == !parBad_q)
        else $error("parity flag wrong on accepted snoop");
    a_shared_stays: assert property (cacheMode == 2'h2 && accValid && accWrite && accHit && accShared |=> !accSetModified)
        else $error("shared line made modified");
    a_miss_to_mem: assert property (cacheMode == 2'h2 && accValid && accWrite && !accHit |=> accMemWrite && !accAllocate)
        else $error("write miss not sent to memory");
endmodule // cpc_policy_assertions
bind cpc_policy_top cpc_policy_assertions u_chk (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .accValid(accValid), .accWrite(accWrite),
    .accHit(accHit), .accShared(accShared), .snoopValid(snoopValid),
    .snoopAddr(snoopAddr), .snoopParity(snoopParity),
    .cacheDropInstr(cacheDropInstr),
    .cacheFlushDropInstr(cacheFlushDropInstr), .accAllocate(accAllocate),
    .accMemWrite(accMemWrite), .accSetModified(accSetModified),
    .l1SnoopEn(l1SnoopEn), .l23SnoopEn(l23SnoopEn),
    .snoopInvalidate(snoopInvalidate), .invalidateAll(invalidateAll),
    .addrParityErrOut_n(addrParityErrOut_n),
    .protectionFault(protectionFault), .cacheMode(cacheMode));

// ### testbench/cpc_bus_agent.sv
// System bus agent model: snoop traffic and external caching pins.
// Assumes the bench calls its tasks; it changes signals after clk edges.
`timescale 1ns/1ps
module cpc_bus_agent (
    input  wire logic        clk,
    output logic             snoopValid,
    output logic [31:0]      snoopAddr,
    output logic             snoopParity,
    output logic             extCacheEnableIn_n,
    output logic             extWritePolicyIn
);
    // Idle bus, caching enabled, write-back chosen
    initial begin
        snoopValid = 1'b0;
        snoopAddr = 32'h0;
        snoopParity = 1'b0;
        extCacheEnableIn_n = 1'b0;
        extWritePolicyIn = 1'b0;
    end
    // One snoop; bad flips the even parity; bus scrambled once released
    task snoop(input logic [31:0] a, input logic bad);
        @(posedge clk);
        snoopValid <= 1'b1;
        snoopAddr <= a;
        snoopParity <= (^a) ^ bad;
        @(posedge clk);
        snoopValid <= 1'b0;
        snoopAddr <= ~a;
        snoopParity <= ~((^a) ^ bad);
    endtask
    // External steering of caching and write policy
    task steer(input logic en_n, input logic wt);
        @(posedge clk);
        extCacheEnableIn_n <= en_n;
        extWritePolicyIn <= wt;
    endtask
endmodule // cpc_bus_agent

// ### testbench/tb_cache_policy_control.sv
// Bench for the cache policy block: APB register calls and access checks.
// Assumes cpc_policy_top with default variant and the bus agent model.
`timescale 1ns/1ps
module tb_cache_policy_control;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, accValid = 1, accWrite = 0, accHit = 0;
    logic accShared = 0, accIsDir = 0, pcOff = 0, page_write_through_bit = 0, pGlb = 0;
    logic drop = 0, flushDrop = 0, sV, sP, extEn_n, extWp, pfSeen = 0;
    logic [31:0] sA;
    logic cab, wt, alloc, memW, setMod, glb, l3, l1S, l23S, sInv, invAll;
    logic perr_n, pf, offPin, wtPin;
    logic [1:0] mode;
    int fails = 0, nCompared = 0;
    cpc_policy_top cpc_policy_top_i (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .dualProcStrap(1'b0), .accValid(accValid), .accWrite(accWrite),
        .accHit(accHit), .accShared(accShared), .accIsDir(accIsDir),
        .accAddr(32'h00001000), .pageCacheOffBit(pcOff),
        .pageWriteThroughBit(page_write_through_bit), .pageGlobalBit(pGlb), .pageAttrIdx(3'h0),
        .extCacheEnableIn_n(extEn_n), .extWritePolicyIn(extWp),
        .snoopValid(sV), .snoopAddr(sA), .snoopParity(sP),
        .cacheDropInstr(drop), .cacheFlushDropInstr(flushDrop),
        .accCacheable(cab), .accWriteThrough(wt), .accAllocate(alloc),
        .accMemWrite(memW), .accSetModified(setMod), .accGlobal(glb),
        .l3Cacheable(l3), .pageCacheOffPin(offPin),
        .pageWriteThroughPin(wtPin),
        .l1SnoopEn(l1S), .l23SnoopEn(l23S), .snoopInvalidate(sInv),
        .invalidateAll(invAll), .addrParityErrOut_n(perr_n),
        .protectionFault(pf), .cacheMode(mode));
    cpc_bus_agent cpc_bus_agent_i (.clk(clk), .snoopValid(sV),
        .snoopAddr(sA), .snoopParity(sP), .extCacheEnableIn_n(extEn_n),
        .extWritePolicyIn(extWp));
    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    // Sticky record of the fault pulse
    always @(posedge clk) if (pf === 1'b1) pfSeen <= 1'b1;
    task tally_and_finish;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            tally_and_finish;
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Access {write,hit,shared,dir,cacheoff,writethrough,global}; settle
    task acc(input logic [6:0] f);
        @(posedge clk);
        {accWrite, accHit, accShared, accIsDir, pcOff, page_write_through_bit, pGlb} <= f;
        @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        apb(0, 12'h000, 0); chk("primary", 32'h60000000, q);
        chk("mode", 2, mode);
        apb(0, 12'h0FC, 0); chk("unmapped", 0, q);
        $display("test reset done");
        apb(1, 12'h000, 32'h20000000); repeat (2) @(posedge clk);
        chk("fault", 1, pfSeen);
        apb(0, 12'h000, 0); chk("primary kept", 32'h60000000, q);
        apb(0, 12'h014, 0); chk("fault code", 0, q[15:0]);
        chk("fault count", 1, q[23:16]);
        $display("test illegal done");
        apb(1, 12'h040, 32'h66666666);
        acc(7'b1000000); chk("memwrite", 1, memW);
        chk("alloc", 0, alloc);
        acc(7'b1100000); chk("modified", 1, setMod);
        acc(7'b1110000); chk("shared", 0, setMod);
        acc(7'b0000000); chk("readmiss", 0, alloc);
        cpc_bus_agent_i.snoop(32'h12345678, 0); #1;
        chk("snoopinv", 0, sInv);
        chk("l1snoop", 0, l1S); chk("l23snoop", 1, l23S);
        for (int i = 1; i < 3; i++) begin
            @(posedge clk); {flushDrop, drop} <= i[1:0];
            @(posedge clk); {flushDrop, drop} <= 2'b00; #1;
            chk("invall", 1, invAll);
        end
        $display("test no-coherency done");
        apb(1, 12'h000, 32'h80000000); #1; chk("mode", 0, mode);
        apb(0, 12'h000, 0); chk("primary", 32'h80000000, q);
        acc(7'b0000000); chk("cab", 1, cab); chk("alloc", 1, alloc);
        chk("wt", 0, wt);
        acc(7'b0000100); chk("pagecoff", 0, cab);
        chk("offpin", 0, offPin); chk("wtpin", 0, wtPin);
        acc(7'b0000010); chk("pagewt", 1, wt);
        cpc_bus_agent_i.snoop(32'h0000ABCD, 0); #1; chk("perr", 1, perr_n);
        chk("l1snoop", 1, l1S);
        cpc_bus_agent_i.snoop(32'h0000ABCD, 1); #1; chk("perr", 0, perr_n);
        apb(1, 12'h004, 32'h10); acc(7'b0001000); chk("dircab", 0, cab);
        acc(7'b0000000); chk("tblcab", 1, cab);
        apb(1, 12'h004, 32'h08); acc(7'b0001000); chk("dirwt", 1, wt);
        acc(7'b0000000); chk("tblwt", 0, wt);
        acc(7'b0000001); chk("glboff", 0, glb);
        apb(1, 12'h008, 32'h80); acc(7'b0000001); chk("glbon", 1, glb);
        apb(1, 12'h00C, 32'h40); acc(0); chk("l3", 0, l3);
        chk("l1cab", 1, cab);
        apb(1, 12'h00C, 0); acc(0); chk("l3", 1, l3);
        apb(1, 12'h020, 32'h08); acc(0); chk("regionuc", 0, cab);
        chk("regionalloc", 0, alloc);
        apb(1, 12'h020, 0);
        apb(1, 12'h040, 32'h66666660); acc(0); chk("attruc", 0, cab);
        apb(1, 12'h040, 32'h66666666);
        cpc_bus_agent_i.steer(1, 0); acc(0); chk("extenoff", 0, cab);
        cpc_bus_agent_i.steer(0, 1); acc(0); chk("extwt", 1, wt);
        apb(1, 12'h000, 32'hC0000000); acc(0); chk("mode", 1, mode);
        chk("nofill", 0, alloc);
        $display("test normal mode done");
        tally_and_finish;
    end
endmodule // tb_cache_policy_control
